//--- ddri_pkg.sv
/*
 * Shared constants for the DRAM reset, initialisation and mode register controller:
 * timing figures, derived cycle counts, pin command codes, address bit positions,
 * software register offsets and field positions, opcodes and states.
 * Assumes a 100 MHz system clock; every system clock cycle count below is derived from that rate.
 */
package ddri_pkg;

	// System clock rate
	localparam int CLK_MHZ = 100;

	// Reset and wake-up times, in their printed units
	localparam int T_RST_PU_US  = 200;
	localparam int T_RST_SP_NS  = 100;
	localparam int T_CKE_PRE_NS = 10;
	localparam int T_RST_CKE_US = 500;

	// Derived counts of system clock cycles (least times round up)
	localparam int RST_PU_CYC  = T_RST_PU_US * CLK_MHZ;
	localparam int RST_SP_CYC  = (T_RST_SP_NS * CLK_MHZ + 999) / 1000;
	localparam int CKE_PRE_CYC = (T_CKE_PRE_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_CKE_CYC = T_RST_CKE_US * CLK_MHZ;

	// Memory-side intervals in memory clock periods; plain defaults
	localparam int CK_STABLE_TCK = 5;
	localparam int T_XS_TCK      = 100;
	localparam int T_XPR_TCK     = (T_XS_TCK > 5) ? T_XS_TCK : 5;
	localparam int T_MRD_TCK     = 4;
	localparam int T_MOD_TCK     = 12;
	localparam int T_DLLK_TCK    = 512;
	localparam int T_ZQINIT_TCK  = 512;
	localparam int T_FINAL_TCK   = (T_DLLK_TCK > T_ZQINIT_TCK) ? T_DLLK_TCK : T_ZQINIT_TCK;
	localparam int T_GAP_TCK     = 8;

	// Pin commands as {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP  = 4'h7;
	localparam logic [3:0] CMD_MRS  = 4'h0;
	localparam logic [3:0] CMD_ACT  = 4'h3;
	localparam logic [3:0] CMD_RD   = 4'h5;
	localparam logic [3:0] CMD_WR   = 4'h4;
	localparam logic [3:0] CMD_PRE  = 4'h2;
	localparam logic [3:0] CMD_ZQCL = 4'h6;

	// Address bit positions with a fixed meaning
	localparam int A_DLL_DIS_BIT = 0;
	localparam int A_DLL_RST_BIT = 8;
	localparam int A_AP_BIT      = 10;
	localparam int A_BC_BIT      = 12;

	// Software register offsets
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_CMD    = 4'h2;
	localparam logic [3:0] REG_MR0    = 4'h4;

	// Field positions
	localparam int CTRL_REINIT_BIT = 0;
	localparam int CTRL_ODT_BIT    = 1;
	localparam int STAT_READY_BIT  = 0;
	localparam int STAT_ERR_BIT    = 1;
	localparam int STAT_PEND_BIT   = 2;
	localparam int STAT_STATE_LSB  = 8;
	localparam int STAT_OPEN_LSB   = 24;
	localparam int CMD_OP_LSB      = 0;
	localparam int CMD_BA_LSB      = 3;
	localparam int CMD_A_LSB       = 6;

	// Values after reset
	localparam logic [12:0] MR_RST  = 13'h0000;
	localparam logic [18:0] CMD_RST = 19'h0_0000;

	// Software command opcodes
	typedef enum logic [2:0] {
		OP_ACT  = 3'h1,
		OP_RD   = 3'h2,
		OP_WR   = 3'h3,
		OP_MRS  = 3'h4,
		OP_PREA = 3'h5
	} ddri_op_t;

	// Sequencer states, one-hot
	typedef enum logic [7:0] {
		ST_RST    = 8'h01,
		ST_WAKE   = 8'h02,
		ST_XPR    = 8'h04,
		ST_MRS    = 8'h08,
		ST_FINAL  = 8'h10,
		ST_IDLE   = 8'h20,
		ST_ODTOFF = 8'h40,
		ST_GAP    = 8'h80
	} ddri_state_t;

endpackage

//--- ddri_init_ctrl.sv
/*
 * Controller that brings an eight-bank DDR memory out of reset, programs its mode
 * registers and then issues software commands through a plain register port.
 * Assumes the memory pins are wired straight to the outputs; the memory clock is
 * made here by dividing clk, and commands change on its falling edge.
 */
// Added by the designer: strobed register access and the address map.
// Summary of operation
// - Activate opens bank and row before any read or write to it.
// - Power-up reset held 200 us; CKE low 10 ns before release.
// - Wait 500 us after reset release before raising CKE.
// - Clock stable and NOP registered before CKE rises.
// - CKE stays high from first rise until initialisation ends.
// - ODT held static, low here, during initialisation.
// - Wait tXPR after CKE rises before first mode register write.
// - First mode writes go to MR2, then MR3.
// - Then MR1 with DLL enabled, then MR0 with DLL reset.
// - ZQCL after MR0 with only NOPs between; then wait tDLLK and tZQinit.
// - Stable-power reset held 100 ns, then same sequence from 500 us wait.
// - Every mode register written in full after any reset.
// - Consecutive mode writes spaced by at least tMRD.
// - Nothing but NOP within tMOD after a mode write; here the init mode writes follow each other at tMRD.
// - Later mode writes only with all banks closed and bursts done.
// - ODT low before a mode write, high again only after tMOD.
// - Mode writes drive all command pins low; BA2 always zero.
// - MR0 write recovery field at least tWR over clock period, rounded up; here sent as written in the MR0 image.
module ddri_init_ctrl
	import ddri_pkg::*;
#(
	parameter int CK_DIV         = 4,
	parameter int RST_PU_CYCLES  = RST_PU_CYC,
	parameter int RST_CKE_CYCLES = RST_CKE_CYC
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             dram_ck,
	output logic             dram_ck_n,
	output logic             dram_reset_n,
	output logic             dram_cke,
	output logic             dram_odt,
	output logic             dram_cs_n,
	output logic             dram_ras_n,
	output logic             dram_cas_n,
	output logic             dram_we_n,
	output logic      [2:0]  dram_ba,
	output logic      [12:0] dram_a
);

	localparam int WW   = 17;
	localparam int DIVW = $clog2(CK_DIV);
	localparam logic [DIVW-1:0] DIV_LAST = DIVW'(CK_DIV - 1);
	localparam logic [DIVW-1:0] HALF_M1  = DIVW'(CK_DIV / 2 - 1);

	// Refuse settings the counters and divider cannot serve
	if (CK_DIV < 2 || CK_DIV % 2 != 0 || RST_PU_CYCLES < RST_SP_CYC
		|| RST_CKE_CYCLES >= 2 ** WW - 1 || RST_PU_CYCLES >= 2 ** WW
		|| T_FINAL_TCK * CK_DIV >= 2 ** WW) begin : g_bad_param
		$error("ddri_init_ctrl: unsupported parameter values");
	end

	function automatic logic [WW-1:0] tck_cyc(input int n);
		return WW'(n * CK_DIV - 1);
	endfunction

	logic              rst_meta_reg, rst_sync_reg, rst_n;
	logic [DIVW-1:0]   div_reg;
	logic              ck_reg, ck_n_reg, slot;
	ddri_state_t       state_reg, state_next;
	logic [WW-1:0]     wait_reg, wait_next;
	logic [1:0]        step_reg, step_next;
	logic              rst_pin_reg, cke_reg, odt_reg, odt_next;
	logic [3:0]        cmd_reg, issue_cmd;
	logic [2:0]        ba_reg, issue_ba;
	logic [12:0]       a_reg, issue_a, init_data;
	logic [1:0]        init_sel;
	logic              issue, take, refuse, wait_done;
	logic [7:0]        open_reg;
	logic              odt_en_reg, reinit_reg, pend_reg, err_reg;
	logic [18:0]       cmd_word_reg;
	logic [12:0]       mr_reg [4];
	logic [31:0]       rdata_reg;
	ddri_op_t          op;
	logic [2:0]        cmd_bank;
	logic [12:0]       cmd_a;

	// Reset release through two flops; assertion is immediate
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// Memory clock divider; runs from reset so it is long stable before CKE
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg  <= '0;
			ck_reg   <= 1'b0;
			ck_n_reg <= 1'b1;
		end else begin
			div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
			if (div_reg == DIV_LAST) begin
				ck_reg   <= 1'b1;
				ck_n_reg <= 1'b0;
			end else if (div_reg == HALF_M1) begin
				ck_reg   <= 1'b0;
				ck_n_reg <= 1'b1;
			end
		end
	end
	// Pins change with the falling memory clock, half a period of setup
	assign slot = (div_reg == HALF_M1);

	// Init order MR2, MR3, MR1, MR0 from step 0..3
	assign init_sel = {~step_reg[1], step_reg[1] ^ step_reg[0]};
	always_comb begin
		init_data = mr_reg[init_sel];
		if (init_sel == 2'd1) begin
			init_data[A_DLL_DIS_BIT] = 1'b0;
		end
		if (init_sel == 2'd0) begin
			init_data[A_DLL_RST_BIT] = 1'b1;
		end
	end

	assign op        = ddri_op_t'(cmd_word_reg[CMD_OP_LSB +: 3]);
	assign cmd_bank  = cmd_word_reg[CMD_BA_LSB +: 3];
	assign cmd_a     = cmd_word_reg[CMD_A_LSB +: 13];
	assign wait_done = (wait_reg == '0);

	// Sequencer: next state, waits and the command for the next slot
	always_comb begin
		state_next = state_reg;
		wait_next  = wait_done ? wait_reg : wait_reg - 1'b1;
		step_next  = step_reg;
		odt_next   = odt_reg;
		issue      = 1'b0;
		issue_cmd  = CMD_NOP;
		issue_ba   = 3'h0;
		issue_a    = 13'h0000;
		take       = 1'b0;
		refuse     = 1'b0;
		unique case (state_reg)
			ST_RST: begin
				odt_next = 1'b0;
				if (wait_done) begin
					state_next = ST_WAKE;
					wait_next  = WW'(RST_CKE_CYCLES - 1);
				end
			end
			ST_WAKE: begin
				// Only NOP has been driven since reset, so CKE may rise here
				if (wait_done && slot) begin
					state_next = ST_XPR;
					wait_next  = tck_cyc(T_XPR_TCK);
				end
			end
			ST_XPR, ST_MRS: begin
				if (wait_done && slot) begin
					issue = 1'b1;
					if (state_reg == ST_MRS && step_reg == 2'd0) begin
						issue_cmd           = CMD_ZQCL;
						issue_a[A_AP_BIT]   = 1'b1;
						state_next          = ST_FINAL;
						wait_next           = tck_cyc(T_FINAL_TCK);
					end else begin
						issue_cmd  = CMD_MRS;
						issue_ba   = {1'b0, init_sel};
						issue_a    = init_data;
						step_next  = step_reg + 2'd1;
						state_next = ST_MRS;
						// Last write is followed by ZQCL, so it needs tMOD
						wait_next = (step_reg == 2'd3) ? tck_cyc(T_MOD_TCK)
							: tck_cyc(T_MRD_TCK);
					end
				end
			end
			ST_FINAL: begin
				if (wait_done && slot) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (slot) begin
					odt_next = odt_en_reg;
					if (pend_reg) begin
						take = 1'b1;
						unique case (op)
							OP_ACT:  refuse = open_reg[cmd_bank];
							OP_RD, OP_WR: refuse = !open_reg[cmd_bank];
							OP_MRS:  refuse = (open_reg != 8'h00);
							OP_PREA: refuse = 1'b0;
							default: refuse = 1'b1;
						endcase
						if (!refuse && op == OP_MRS && odt_reg) begin
							take       = 1'b0;
							odt_next   = 1'b0;
							state_next = ST_ODTOFF;
						end else if (!refuse) begin
							issue      = 1'b1;
							issue_ba   = cmd_bank;
							issue_a    = cmd_a;
							state_next = ST_GAP;
							wait_next  = tck_cyc(T_GAP_TCK);
							unique case (op)
								OP_ACT:  issue_cmd = CMD_ACT;
								OP_RD:   issue_cmd = CMD_RD;
								OP_WR:   issue_cmd = CMD_WR;
								OP_PREA: begin
									issue_cmd         = CMD_PRE;
									issue_ba          = 3'h0;
									issue_a           = 13'h0000;
									issue_a[A_AP_BIT] = 1'b1;
								end
								default: begin
									issue_cmd = CMD_MRS;
									issue_ba  = {1'b0, cmd_bank[1:0]};
									issue_a   = mr_reg[cmd_bank[1:0]];
									odt_next  = 1'b0;
									wait_next = tck_cyc(T_MOD_TCK);
								end
							endcase
						end
					end
				end
			end
			ST_ODTOFF: begin
				// ODT was registered low one memory clock (CK_DIV clocks) before this write
				if (slot) begin
					issue      = 1'b1;
					take       = 1'b1;
					issue_cmd  = CMD_MRS;
					issue_ba   = {1'b0, cmd_bank[1:0]};
					issue_a    = mr_reg[cmd_bank[1:0]];
					state_next = ST_GAP;
					wait_next  = tck_cyc(T_MOD_TCK);
				end
			end
			ST_GAP: begin
				if (wait_done && slot) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_RST;
				wait_next  = WW'(RST_SP_CYC - 1);
			end
		endcase
		// Stable-power reset from any state
		if (reinit_reg) begin
			state_next = ST_RST;
			wait_next  = WW'(RST_SP_CYC - 1);
			step_next  = 2'd0;
			odt_next   = 1'b0;
			issue      = 1'b0;
			take       = 1'b1;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_RST;
			wait_reg  <= WW'(RST_PU_CYCLES - 1);
			step_reg  <= 2'd0;
		end else begin
			state_reg <= state_next;
			wait_reg  <= wait_next;
			step_reg  <= step_next;
		end
	end

	// Memory pins; CKE falls with reset, so it is low long before release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pin_reg <= 1'b0;
			cke_reg     <= 1'b0;
			odt_reg     <= 1'b0;
			cmd_reg     <= CMD_NOP;
			ba_reg      <= 3'h0;
			a_reg       <= 13'h0000;
		end else begin
			rst_pin_reg <= (state_next != ST_RST);
			cke_reg     <= (state_next != ST_RST) && (state_next != ST_WAKE);
			odt_reg     <= odt_next;
			if (issue) begin
				cmd_reg <= issue_cmd;
				ba_reg  <= issue_ba;
				a_reg   <= issue_a;
			end else if (slot || reinit_reg) begin
				cmd_reg <= CMD_NOP;
			end
		end
	end

	// Open-bank tracking for command legality
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			open_reg <= 8'h00;
		end else if (state_next == ST_RST) begin
			open_reg <= 8'h00;
		end else if (issue && issue_cmd == CMD_ACT) begin
			open_reg[issue_ba] <= 1'b1;
		end else if (issue && (issue_cmd == CMD_RD || issue_cmd == CMD_WR)
			&& issue_a[A_AP_BIT]) begin
			open_reg[issue_ba] <= 1'b0;
		end else if (issue && issue_cmd == CMD_PRE) begin
			open_reg <= 8'h00;
		end
	end

	// Control, command and status bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			odt_en_reg   <= 1'b0;
			reinit_reg   <= 1'b0;
			cmd_word_reg <= CMD_RST;
			pend_reg     <= 1'b0;
			err_reg      <= 1'b0;
		end else begin
			reinit_reg <= reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_REINIT_BIT];
			if (reg_wr && reg_addr == REG_CTRL) begin
				odt_en_reg <= reg_wdata[CTRL_ODT_BIT];
			end
			if (reg_wr && reg_addr == REG_CMD) begin
				cmd_word_reg <= reg_wdata[18:0];
			end
			// A new command written in the cycle one is taken stays pending
			if (reg_wr && reg_addr == REG_CMD) begin
				pend_reg <= 1'b1;
			end else if (take) begin
				pend_reg <= 1'b0;
			end
			// Refusal wins over a software clear in the same cycle
			if (refuse) begin
				err_reg <= 1'b1;
			end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_ERR_BIT]) begin
				err_reg <= 1'b0;
			end
		end
	end

	// Mode register images, one per register
	for (genvar i = 0; i < 4; i++) begin : g_mr
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mr_reg[i] <= MR_RST;
			end else if (reg_wr && reg_addr == REG_MR0 + 4'(i)) begin
				mr_reg[i] <= reg_wdata[12:0];
			end
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (reg_rd) begin
			rdata_reg <= 32'h0000_0000;
			if (reg_addr == REG_CTRL) begin
				rdata_reg[CTRL_ODT_BIT] <= odt_en_reg;
			end else if (reg_addr == REG_STATUS) begin
				rdata_reg[STAT_READY_BIT]      <= (state_reg == ST_IDLE);
				rdata_reg[STAT_ERR_BIT]        <= err_reg;
				rdata_reg[STAT_PEND_BIT]       <= pend_reg;
				rdata_reg[STAT_STATE_LSB +: 8] <= state_reg;
				rdata_reg[STAT_OPEN_LSB +: 8]  <= open_reg;
			end else if (reg_addr == REG_CMD) begin
				rdata_reg[18:0] <= cmd_word_reg;
			end else if (reg_addr[3:2] == REG_MR0[3:2]) begin
				rdata_reg[12:0] <= mr_reg[reg_addr[1:0]];
			end
		end
	end

	assign reg_rdata    = rdata_reg;
	assign dram_ck      = ck_reg;
	assign dram_ck_n    = ck_n_reg;
	assign dram_reset_n = rst_pin_reg;
	assign dram_cke     = cke_reg;
	assign dram_odt     = odt_reg;
	assign {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n} = cmd_reg;
	assign dram_ba      = ba_reg;
	assign dram_a       = a_reg;

	// Helper counters watched only by the checks below
	logic          fresh_reg, mrs_seen_reg;
	logic [15:0]   since_mrs_reg, low_cnt_reg;
	logic [WW:0]   since_rel_reg;
	logic [2:0]    last_ba_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fresh_reg     <= 1'b0;
			mrs_seen_reg  <= 1'b0;
			since_mrs_reg <= 16'h0000;
			low_cnt_reg   <= 16'h0000;
			since_rel_reg <= '0;
			last_ba_reg   <= 3'h0;
		end else begin
			fresh_reg <= issue;
			if (fresh_reg && cmd_reg == CMD_MRS) begin
				since_mrs_reg <= 16'h0001;
				mrs_seen_reg  <= 1'b1;
				last_ba_reg   <= ba_reg;
			end else if (since_mrs_reg != 16'hFFFF) begin
				since_mrs_reg <= since_mrs_reg + 16'h0001;
			end
			low_cnt_reg <= rst_pin_reg ? 16'h0000
				: (low_cnt_reg == 16'hFFFF) ? low_cnt_reg : low_cnt_reg + 16'h0001;
			since_rel_reg <= !rst_pin_reg ? '0
				: (&since_rel_reg) ? since_rel_reg : since_rel_reg + 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_nop_before;
		cmd_reg == CMD_NOP && $past(cmd_reg) == CMD_NOP;
	endsequence
	sequence s_cke_rise;
		$rose(cke_reg);
	endsequence

	chk_cke_low_reset: assert property (!rst_pin_reg |-> !cke_reg)
		else $error("CKE high while memory reset is asserted");
	chk_reset_hold: assert property ($rose(rst_pin_reg) |-> low_cnt_reg >= 16'(RST_SP_CYC))
		else $error("Memory reset released too early");
	chk_wake_wait: assert property (s_cke_rise |-> since_rel_reg >= (WW+1)'(RST_CKE_CYCLES))
		else $error("CKE raised before the wake-up wait");
	chk_nop_cke: assert property (s_cke_rise |-> s_nop_before)
		else $error("CKE raised without NOP registered");
	chk_cke_held: assert property (cke_reg && rst_pin_reg |=> cke_reg || !rst_pin_reg)
		else $error("CKE dropped outside reset");
	chk_odt_init: assert property (cke_reg && state_reg inside {ST_XPR, ST_MRS, ST_FINAL} |-> !odt_reg)
		else $error("ODT not held low during initialisation");
	chk_mrs_ba2_zero: assert property (cmd_reg == CMD_MRS |-> !ba_reg[2])
		else $error("BA2 set during a mode write");
	chk_mrd_gap: assert property (fresh_reg && cmd_reg == CMD_MRS && mrs_seen_reg
		|-> since_mrs_reg >= 16'(T_MRD_TCK * CK_DIV))
		else $error("Mode writes closer than tMRD");
	chk_mod_gap: assert property (fresh_reg && cmd_reg != CMD_MRS && mrs_seen_reg
		|-> since_mrs_reg >= 16'(T_MOD_TCK * CK_DIV))
		else $error("Command issued within tMOD of a mode write");
	chk_zq_after_mr0: assert property (fresh_reg && cmd_reg == CMD_ZQCL |-> last_ba_reg == 3'h0)
		else $error("ZQCL not preceded by the MR0 write");
	chk_odt_mrs: assert property (fresh_reg && cmd_reg == CMD_MRS |-> !odt_reg && !$past(odt_reg))
		else $error("ODT high around a mode write");

endmodule

//--- ddri_mem_model.sv
/*
 * Behavioural model of the eight-bank memory on the controller's pins.
 * Assumes pins are stable at each rising memory clock; counts violations in viol.
 */
module ddri_mem_model
	import ddri_pkg::*;
#(
	parameter real WAKE_NS = 600.0
) (
	input  wire logic        ck,
	input  wire logic        reset_n,
	input  wire logic        cke,
	input  wire logic        odt,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  ba,
	input  wire logic [12:0] a,
	output int               viol,
	output int               mrs_cnt,
	output int               cmd_cnt,
	output logic             init_done,
	output logic             term_on,
	output logic [7:0]       open_banks,
	output logic [3:0]       last_cmd,
	output logic [2:0]       last_ba,
	output logic [12:0]      last_a,
	output logic [3:0][12:0] mr
);
	timeunit 1ns;
	timeprecision 1ps;
	realtime          t_rst = 0;
	realtime          t_rel = 0;
	int               ck_cnt = 0;
	int               since_cke = 0;
	int               since_mrs = 1000;
	int               since_zq = 0;
	int               seq = 0;
	logic             cke_seen = 0;
	logic             zq_seen = 0;
	logic             odt0 = 0;
	logic [3:0]       cmd;
	logic [3:0][1:0]  ord = {2'd0, 2'd1, 2'd3, 2'd2};
	initial viol = 0;
	initial mrs_cnt = 0;
	initial cmd_cnt = 0;
	initial open_banks = 8'h00; // Eight banks
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign init_done = zq_seen && since_zq >= T_FINAL_TCK;
	// Termination stays off until CKE is seen high after reset
	assign term_on = reset_n && cke_seen && odt;

	// Reset entry forgets all progress
	always @(negedge reset_n) begin
		t_rst = $realtime;
		cke_seen = 0;
		zq_seen = 0;
		seq = 0;
		since_mrs = 1000;
		open_banks = 8'h00;
	end
	// Reset release: minimum width and CKE low
	always @(posedge reset_n) begin
		if ($realtime - t_rst < 100.0 || cke !== 1'b0) viol++;
		t_rel = $realtime;
		ck_cnt = 0;
	end
	// Command decode at each registered clock edge
	always @(posedge ck) if (reset_n === 1'b1) begin
		ck_cnt++;
		since_cke++;
		since_mrs++;
		since_zq++;
		if (!cke_seen && cke === 1'b1) begin
			if ($realtime - t_rel < WAKE_NS || ck_cnt < CK_STABLE_TCK) viol++;
			if (cmd !== CMD_NOP) viol++;
			cke_seen = 1;
			since_cke = 0;
			odt0 = odt;
		end
		if (cke_seen && !init_done && (cke !== 1'b1 || odt !== odt0)) viol++;
		if (cmd != CMD_NOP && cmd != CMD_MRS && since_mrs < T_MOD_TCK) viol++;
		if (zq_seen && !init_done && cmd != CMD_NOP && cmd != CMD_ZQCL) viol++;
		if (odt && since_mrs < T_MOD_TCK) viol++;
		case (cmd)
			CMD_MRS: begin
				if (ba[2] || since_mrs < T_MRD_TCK || odt || open_banks != 0) viol++;
				if (!zq_seen && (since_cke < T_XPR_TCK || seq > 3 || ba[1:0] != ord[seq])) viol++;
				if (!zq_seen && ((ba[1:0] == 2'd1 && a[0]) || (ba[1:0] == 2'd0 && !a[8]))) viol++;
				mr[ba[1:0]] = a; // Only the mode image changes, never bank state
				seq++;
				since_mrs = 0;
				mrs_cnt++;
			end
			CMD_ZQCL: begin
				if (seq != 4) viol++;
				zq_seen = 1;
				since_zq = 0;
			end
			CMD_ACT: if (open_banks[ba]) viol++; else open_banks[ba] = 1;
			CMD_RD, CMD_WR: begin
				if (!open_banks[ba]) viol++;
				if (a[10]) open_banks[ba] = 0;
			end
			CMD_PRE: if (a[10]) open_banks = 8'h00; else open_banks[ba] = 0;
			default: ;
		endcase
		if (cmd != CMD_NOP) begin
			last_cmd = cmd;
			last_ba = ba;
			last_a = a;
			cmd_cnt++;
		end
	end
endmodule

//--- testbench.sv
/*
 * Self-checking bench for the memory initialisation controller.
 * Assumes the memory model beside it; reset counts are shortened by parameters.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ddri_pkg::*;
	logic        clk = 0;
	logic        resetn = 0;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic [31:0] reg_rdata;
	logic        dram_ck, dram_ck_n, dram_reset_n, dram_cke, dram_odt;
	logic        dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n;
	logic [2:0]  dram_ba;
	logic [12:0] dram_a;
	int          viol, mrs_cnt, cmd_cnt;
	logic        init_done, term_on;
	logic [7:0]  open_banks;
	logic [3:0]  last_cmd;
	logic [2:0]  last_ba;
	logic [12:0] last_a;
	logic [3:0][12:0] mr;
	int          miscompares = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [31:0] s;

	ddri_init_ctrl #(.CK_DIV(4), .RST_PU_CYCLES(40), .RST_CKE_CYCLES(60)) i_ddri_init_ctrl (
		.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dram_ck(dram_ck),
		.dram_ck_n(dram_ck_n), .dram_reset_n(dram_reset_n), .dram_cke(dram_cke),
		.dram_odt(dram_odt), .dram_cs_n(dram_cs_n), .dram_ras_n(dram_ras_n),
		.dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n), .dram_ba(dram_ba), .dram_a(dram_a));
	ddri_mem_model #(.WAKE_NS(600.0)) i_ddri_mem_model (
		.ck(dram_ck), .reset_n(dram_reset_n), .cke(dram_cke), .odt(dram_odt), .cs_n(dram_cs_n),
		.ras_n(dram_ras_n), .cas_n(dram_cas_n), .we_n(dram_we_n), .ba(dram_ba), .a(dram_a),
		.viol(viol), .mrs_cnt(mrs_cnt), .cmd_cnt(cmd_cnt), .init_done(init_done),
		.term_on(term_on), .open_banks(open_banks), .last_cmd(last_cmd), .last_ba(last_ba),
		.last_a(last_a), .mr(mr));

	always #5 clk = ~clk;
	// Hang guard: init twice is well under this ceiling
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	// Read data appears in the cycle after the strobe and holds until the next strobe
	task automatic rd_reg(input logic [3:0] ad, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 2000; i++) begin
			rd_reg(REG_STATUS, s);
			if (s[0] === 1'b1 && s[2] === 1'b0) break;
		end
		check(s[0], 1, "ready");
	endtask
	task automatic issue(input logic [2:0] op, input logic [2:0] bk, input logic [12:0] ad);
		wr_reg(REG_CMD, {13'h0000, ad, bk, op});
		wait_ready();
	endtask

	task automatic t_init();
		wait_ready();
		// The memory counts its final wait from its own clock rise, a little later
		repeat (4) @(posedge clk);
		check(init_done, 1, "init done");
		check(mrs_cnt, 4, "mrs count");
		check({mr[1][0], mr[0][8]}, 2'b01, "dll bits");
		check(s, 32'h0000_2001, "status idle");
		check(dram_ck_n, !dram_ck, "ck pair");
		for (int i = 4; i < 8; i++) begin
			rd_reg(4'(i), s);
			check(s, 32'(MR_RST), "mr image reset");
		end
		rd_reg(4'h3, s);
		check(s, 32'h0000_0000, "unmapped");
		rd_reg(REG_CTRL, s);
		check(s, 32'h0000_0000, "ctrl reset");
		$display("test init done");
	endtask
	task automatic t_bank();
		issue(OP_ACT, 3'd5, 13'h1abc);
		check({last_cmd, last_ba, last_a}, {CMD_ACT, 3'd5, 13'h1abc}, "act pins");
		check(s[31:24], 8'h20, "open bank");
		issue(OP_RD, 3'd5, 13'h0408);
		check({last_cmd, last_ba, last_a}, {CMD_RD, 3'd5, 13'h0408}, "rd pins");
		issue(OP_ACT, 3'd7, 13'h0001);
		issue(OP_WR, 3'd7, 13'h1003);
		check({last_cmd, open_banks}, {CMD_WR, 8'h80}, "wr keeps open");
		issue(OP_PREA, 3'd0, 13'h0000);
		check({s[31:24], open_banks}, 16'h0000, "all closed");
		$display("test bank done");
	endtask
	// Each of these must be refused with nothing on the pins
	task automatic t_refuse();
		logic [2:0] ops [4];
		logic [2:0] bks [4];
		int cc;
		ops = '{OP_ACT, OP_RD, OP_MRS, 3'h7};
		bks = '{3'd2, 3'd3, 3'd0, 3'd0};
		issue(OP_ACT, 3'd2, 13'h0010);
		for (int i = 0; i < 4; i++) begin
			cc = cmd_cnt;
			issue(ops[i], bks[i], 13'h0000);
			check({s[2:1], 30'(cmd_cnt)}, {2'b01, 30'(cc)}, "refused");
			wr_reg(REG_STATUS, 32'h0000_0002);
			rd_reg(REG_STATUS, s);
			check(s[1], 0, "err cleared");
		end
		issue(OP_PREA, 3'd0, 13'h0000);
		$display("test refuse done");
	endtask
	task automatic t_mrs_odt();
		wr_reg(REG_CTRL, 32'h0000_0002);
		rd_reg(REG_CTRL, s);
		check(s, 32'h0000_0002, "ctrl odt");
		wr_reg(REG_MR0 + 4'h2, 32'h0000_0a5c);
		issue(OP_MRS, 3'd6, 13'h0000);
		check({last_cmd, last_ba, last_a}, {CMD_MRS, 3'd2, 13'h0a5c}, "mrs pins");
		repeat (8) @(posedge clk);
		check({dram_odt, term_on}, 2'b11, "odt back");
		check(viol, 0, "mrs timing");
		// Software image of MR0 goes out whole, write recovery field included
		wr_reg(REG_MR0, 32'h0000_0e00);
		issue(OP_MRS, 3'd0, 13'h0000);
		check({last_cmd, last_ba, last_a}, {CMD_MRS, 3'd0, 13'h0e00}, "mr0 wr");
		wr_reg(REG_CTRL, 32'h0000_0000);
		$display("test mrs odt done");
	endtask
	task automatic t_reinit();
		int mc;
		mc = mrs_cnt;
		wr_reg(REG_CTRL, 32'h0000_0001);
		repeat (4) @(posedge clk);
		check({dram_reset_n, dram_cke, term_on}, 3'b000, "reinit reset");
		repeat (100) @(posedge clk);
		wait_ready();
		repeat (4) @(posedge clk);
		check(mrs_cnt, mc + 4, "remrs");
		check(init_done, 1, "reinit done");
		$display("test reinit done");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1;
		repeat (3) @(posedge clk);
		t_init();
		t_bank();
		t_refuse();
		t_mrs_odt();
		t_reinit();
		check(viol, 0, "pin rules");
		tally_and_finish();
	end
endmodule
